// ==== core/imu_defs.svh ====
/*
 * Address map, field positions, scale figures and limits of the inertial output register bank.
 * Assumes byte addressing on the serial port, with a 16-bit word at each even address.
 */
// What this block does
// - Rate high word is 16-bit two's complement; zero rate reads 0x0000.
// - Rate high word scale is 0.1 deg/s per bit over +/-2000 deg/s.
// - Rate low word holds 16 resolution bits below the high word's LSB.
// - Rate low/high words sit at 0x04/0x06, 0x08/0x0A, 0x0C/0x0E.
// - Measurement registers are read-only, reset to 0x0000_0000, no flash backup.
// - Acceleration uses the rate axes and carries dynamic and gravity response.
// - Acceleration high and low words join into one 32-bit value, high first.
// - Acceleration high word: two's complement, zero is 0x0000, 12.25 mm/s^2 per bit.
// - Acceleration low word holds 16 resolution bits below the high word's LSB.
// - Acceleration low/high words sit at 0x10/0x12 (x) and 0x14/0x16 (y).
// - Full-scale acceleration high word reads 0x7D00 positive, 0x8300 negative.
`ifndef IMU_DEFS_SVH
`define IMU_DEFS_SVH

`define ADDR_W             7
`define ADDR_RATE_X_LOW    7'h04
`define ADDR_RATE_X_HIGH   7'h06
`define ADDR_RATE_Y_LOW    7'h08
`define ADDR_RATE_Y_HIGH   7'h0A
`define ADDR_RATE_Z_LOW    7'h0C
`define ADDR_RATE_Z_HIGH   7'h0E
`define ADDR_ACCEL_X_LOW   7'h10
`define ADDR_ACCEL_X_HIGH  7'h12
`define ADDR_ACCEL_Y_LOW   7'h14
`define ADDR_ACCEL_Y_HIGH  7'h16

// Serial command word: bit 15 set means write, bits 14:8 the byte address
`define CMD_WRITE_BIT      15
`define CMD_ADDR_MSB       14
`define CMD_ADDR_LSB       8
`define FRAME_BITS         16
`define BIT_CNT_W          4

`define MEAS_RESET         32'h0000_0000
`define UNMAPPED_READ      16'h0000

// Scale of the high words, kept for reference by software models
`define RATE_LSB_MDPS      100
`define RATE_RANGE_DPS     2000
`define ACCEL_LSB_UMPS2    12250
// Saturation limits of the 32-bit values
`define RATE_MAX           32'sh4E20_0000
`define RATE_MIN           32'shB1E0_0000
`define ACCEL_MAX          32'sh7D00_0000
`define ACCEL_MIN          32'sh8300_0000

`define NUM_AXES           5
`define AXIS_IDX_W         3

`endif

// ==== core/imu_pkg.sv ====
/*
 * Types shared by the inertial output register bank and its serial port.
 * Assumes imu_defs.svh is on the include path.
 */
`include "imu_defs.svh"

package imu_pkg;

    // One coherent sample from the sensor path, 32-bit two's complement per axis
    typedef struct packed {
        logic signed [31:0] rate_x;
        logic signed [31:0] rate_y;
        logic signed [31:0] rate_z;
        logic signed [31:0] accel_x;
        logic signed [31:0] accel_y;
    } sample_t;

    typedef struct packed {
        logic                 wr;
        logic [`ADDR_W-1:0]   addr;
        logic [7:0]           data;
    } spi_cmd_t;

    typedef enum logic [1:0] {
        FRAME_IDLE  = 2'b01,
        FRAME_SHIFT = 2'b10
    } frame_state_t;

endpackage : imu_pkg

// ==== core/spi_word_port.sv ====
/*
 * Serial slave shifter, SPI mode 3, 16-bit words, oversampled by core_clk.
 * Assumes sclk is well below core_clk / 4 so every edge is seen after synchronising.
 */
`timescale 1ns/1ps

module spi_word_port
    import imu_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        mosi,
    output logic             miso,
    input  wire logic [15:0] tx_word,
    output logic [15:0]      rx_word,
    output logic             rx_valid
);

    logic [2:0]             sync1_ff;
    logic [2:0]             sync2_ff;
    logic                   sclk_d_ff;
    logic                   cs_n_d_ff;
    frame_state_t           state_ff;
    logic [`BIT_CNT_W-1:0]  bit_cnt_ff;
    logic [15:0]            rx_sh_ff;
    logic [15:0]            tx_sh_ff;
    logic                   cs_n_s;
    logic                   sclk_s;
    logic                   mosi_s;
    logic                   sclk_rise;
    logic                   sclk_fall;
    logic                   frame_start;

    assign cs_n_s      = sync2_ff[2];
    assign sclk_s      = sync2_ff[1];
    assign mosi_s      = sync2_ff[0];
    assign sclk_rise   = sclk_s & ~sclk_d_ff;
    assign sclk_fall   = ~sclk_s & sclk_d_ff;
    assign frame_start = ~cs_n_s & cs_n_d_ff;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_ff <= 3'h6;
            sync2_ff <= 3'h6;
        end else begin
            sync1_ff <= {cs_n, sclk, mosi};
            sync2_ff <= sync1_ff;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_d_ff <= 1'b1;
            cs_n_d_ff <= 1'b1;
        end else begin
            sclk_d_ff <= sclk_s;
            cs_n_d_ff <= cs_n_s;
        end
    end

    // Frame control: deselect aborts a partial word
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff   <= FRAME_IDLE;
            bit_cnt_ff <= '0;
        end else begin
            case (state_ff)
                FRAME_IDLE: begin
                    if (frame_start) begin
                        state_ff   <= FRAME_SHIFT;
                        bit_cnt_ff <= '0;
                    end
                end
                FRAME_SHIFT: begin
                    if (cs_n_s) begin
                        state_ff <= FRAME_IDLE;
                    end else if (sclk_rise) begin
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                end
                default: begin
                    state_ff <= FRAME_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_sh_ff <= 16'h0000;
            rx_word  <= 16'h0000;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (state_ff == FRAME_SHIFT && !cs_n_s && sclk_rise) begin
                rx_sh_ff <= {rx_sh_ff[14:0], mosi_s};
                if (bit_cnt_ff == 4'hF) begin
                    rx_word  <= {rx_sh_ff[14:0], mosi_s};
                    rx_valid <= 1'b1;
                end
            end
        end
    end

    // MSB out at select, next bit on each falling edge after a rising one
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_sh_ff <= 16'h0000;
            miso     <= 1'b0;
        end else if (frame_start) begin
            tx_sh_ff <= tx_word;
            miso     <= tx_word[15];
        end else if (state_ff == FRAME_SHIFT && !cs_n_s && sclk_fall && bit_cnt_ff != 4'h0) begin
            tx_sh_ff <= {tx_sh_ff[14:0], 1'b0};
            miso     <= tx_sh_ff[14];
        end else if (cs_n_s) begin
            miso <= 1'b0;
        end
    end

endmodule : spi_word_port

// ==== core/inertial_output_registers.sv ====
/*
 * Read-only output register bank for three rate axes and two acceleration axes.
 * Assumes the sensor path delivers one coherent sample with a one-cycle strobe on
 * core_clk, and that the host reads over the serial port, the answer to each
 * command word being shifted out in the following frame.
 */
`timescale 1ns/1ps

module inertial_output_registers
    import imu_pkg::*;
(
    input  wire logic    core_clk,
    input  wire logic    arst_n,
    input  wire logic    sample_valid,
    input  wire sample_t sample,
    input  wire logic    cs_n,
    input  wire logic    sclk,
    input  wire logic    mosi,
    output logic         miso
);

    logic signed [31:0]  raw [`NUM_AXES];
    logic signed [31:0]  clamped [`NUM_AXES];
    logic [31:0]         meas_ff [`NUM_AXES];
    logic [15:0]         tx_word_ff;
    logic [15:0]         hold_high_ff;
    logic [`AXIS_IDX_W-1:0] hold_axis_ff;
    logic                hold_valid_ff;
    logic [15:0]         rx_word;
    logic                rx_valid;
    spi_cmd_t            cmd;
    logic [15:0]         nxt_tx_word;
    logic [`AXIS_IDX_W-1:0] sel_axis;
    logic                sel_hit;
    logic                sel_high;

    // Axis order 0..2 rate, 3..4 acceleration; accel shares the rate axes
    assign raw[0] = sample.rate_x;
    assign raw[1] = sample.rate_y;
    assign raw[2] = sample.rate_z;
    assign raw[3] = sample.accel_x;
    assign raw[4] = sample.accel_y;

    // Saturate at full scale so the high words never pass the published extremes
    genvar g;
    generate
        for (g = 0; g < `NUM_AXES; g++) begin : g_clamp
            if (g < 3) begin : g_rate
                always_comb begin
                    if (raw[g] > `RATE_MAX) begin
                        clamped[g] = `RATE_MAX;
                    end else if (raw[g] < `RATE_MIN) begin
                        clamped[g] = `RATE_MIN;
                    end else begin
                        clamped[g] = raw[g];
                    end
                end
            end else begin : g_accel
                always_comb begin
                    if (raw[g] > `ACCEL_MAX) begin
                        clamped[g] = `ACCEL_MAX;
                    end else if (raw[g] < `ACCEL_MIN) begin
                        clamped[g] = `ACCEL_MIN;
                    end else begin
                        clamped[g] = raw[g];
                    end
                end
            end

            // Both words of an axis load together from one sample
            always_ff @(posedge core_clk or negedge arst_n) begin
                if (!arst_n) begin
                    meas_ff[g] <= `MEAS_RESET;
                end else if (sample_valid) begin
                    meas_ff[g] <= clamped[g];
                end
            end
        end
    endgenerate

    spi_word_port u_port (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .cs_n     (cs_n),
        .sclk     (sclk),
        .mosi     (mosi),
        .miso     (miso),
        .tx_word  (tx_word_ff),
        .rx_word  (rx_word),
        .rx_valid (rx_valid)
    );

    assign cmd = spi_cmd_t'(rx_word);

    // Address decode; odd byte addresses select the same word
    always_comb begin
        sel_hit  = 1'b1;
        sel_high = 1'b0;
        sel_axis = 3'h0;
        if ({cmd.addr[6:1], 1'b0} == `ADDR_RATE_X_LOW) begin
            sel_axis = 3'h0;
        end else if ({cmd.addr[6:1], 1'b0} == `ADDR_RATE_X_HIGH) begin
            sel_axis = 3'h0;
            sel_high = 1'b1;
        end else if ({cmd.addr[6:1], 1'b0} == `ADDR_RATE_Y_LOW) begin
            sel_axis = 3'h1;
        end else if ({cmd.addr[6:1], 1'b0} == `ADDR_RATE_Y_HIGH) begin
            sel_axis = 3'h1;
            sel_high = 1'b1;
        end else if ({cmd.addr[6:1], 1'b0} == `ADDR_RATE_Z_LOW) begin
            sel_axis = 3'h2;
        end else if ({cmd.addr[6:1], 1'b0} == `ADDR_RATE_Z_HIGH) begin
            sel_axis = 3'h2;
            sel_high = 1'b1;
        end else if ({cmd.addr[6:1], 1'b0} == `ADDR_ACCEL_X_LOW) begin
            sel_axis = 3'h3;
        end else if ({cmd.addr[6:1], 1'b0} == `ADDR_ACCEL_X_HIGH) begin
            sel_axis = 3'h3;
            sel_high = 1'b1;
        end else if ({cmd.addr[6:1], 1'b0} == `ADDR_ACCEL_Y_LOW) begin
            sel_axis = 3'h4;
        end else if ({cmd.addr[6:1], 1'b0} == `ADDR_ACCEL_Y_HIGH) begin
            sel_axis = 3'h4;
            sel_high = 1'b1;
        end else begin
            sel_hit = 1'b0;
        end
    end

    // Answer word: high word from bits 31:16, low word extends it in 15:0
    always_comb begin
        nxt_tx_word = `UNMAPPED_READ;
        if (!cmd.wr && sel_hit) begin
            if (!sel_high) begin
                nxt_tx_word = meas_ff[sel_axis][15:0];
            end else if (hold_valid_ff && hold_axis_ff == sel_axis) begin
                nxt_tx_word = hold_high_ff;
            end else begin
                nxt_tx_word = meas_ff[sel_axis][31:16];
            end
        end
    end

    // Writes are dropped: every measurement word is read-only
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_word_ff <= `UNMAPPED_READ;
        end else if (rx_valid) begin
            tx_word_ff <= nxt_tx_word;
        end
    end

    // A low-word read pins the matching high word until any high word or another low word is read
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_high_ff  <= 16'h0000;
            hold_axis_ff  <= 3'h0;
            hold_valid_ff <= 1'b0;
        end else if (rx_valid && !cmd.wr && sel_hit) begin
            if (!sel_high) begin
                hold_high_ff  <= meas_ff[sel_axis][31:16];
                hold_axis_ff  <= sel_axis;
                hold_valid_ff <= 1'b1;
            end else begin
                hold_valid_ff <= 1'b0;
            end
        end
    end

endmodule : inertial_output_registers

// ==== sim/spi_host_model.sv ====
/*
 * Host side of the serial port: mode 3 master moving one 16-bit word per frame.
 * Assumes core_clk is the bench clock; sclk half period is HALF core_clk cycles.
 */
`timescale 1ns/1ps

module spi_host_model #(
    parameter int HALF = 6
) (
    input  wire logic core_clk,
    output logic      cs_n,
    output logic      sclk,
    output logic      mosi,
    input  wire logic miso
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        mosi = 1'b0;
    end

    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge core_clk) cs_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        for (int i = 15; i >= 0; i--) begin
            sclk <= 1'b0;
            mosi <= tx[i];
            repeat (HALF) @(posedge core_clk);
            sclk <= 1'b1;
            rx = {rx[14:0], miso};
            repeat (HALF) @(posedge core_clk);
        end
        cs_n <= 1'b1;
        // Line released: show the inverse rather than a stale bit
        mosi <= ~tx[0];
        repeat (10) @(posedge core_clk);
    endtask : xfer
endmodule : spi_host_model

// ==== sim/inertial_output_registers_checker.sv ====
/*
 * Pin-level assertions for the inertial output register bank, bound to its top module.
 * Assumes the host keeps sclk half periods of 6 core_clk or more and idles cs_n high.
 */
`timescale 1ns/1ps
`include "imu_defs.svh"

module inertial_output_registers_checker
    import imu_pkg::*;
(
    input wire logic    core_clk,
    input wire logic    arst_n,
    input wire logic    sample_valid,
    input wire sample_t sample,
    input wire logic    cs_n,
    input wire logic    sclk,
    input wire logic    mosi,
    input wire logic    miso
);
    logic        sclk_ff, cs_ff, done_ff, first_ff, rfirst_ff;
    logic [4:0]  nbits_ff, since_ff;
    logic [15:0] mo_ff, mi_ff, cmd_ff, rcmd_ff, rep_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // Rebuilds command and reply of every full frame
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            {sclk_ff, cs_ff, first_ff} <= 3'h7;
            {done_ff, rfirst_ff, nbits_ff, since_ff} <= '0;
            {mo_ff, mi_ff, cmd_ff, rcmd_ff, rep_ff} <= '0;
        end else begin
            sclk_ff  <= sclk;
            cs_ff    <= cs_n;
            done_ff  <= 1'b0;
            since_ff <= ((sclk_ff && !sclk) || (cs_ff && !cs_n)) ? 5'h00 :
                        (since_ff == 5'h1F) ? since_ff : since_ff + 5'h01;
            if (!cs_n && sclk && !sclk_ff) begin
                mo_ff    <= {mo_ff[14:0], mosi};
                mi_ff    <= {mi_ff[14:0], miso};
                nbits_ff <= nbits_ff + 5'h01;
            end
            if (cs_n && !cs_ff) begin
                nbits_ff <= 5'h00;
                if (nbits_ff == 5'h10) begin
                    done_ff   <= 1'b1;
                    rep_ff    <= mi_ff;
                    rcmd_ff   <= cmd_ff;
                    rfirst_ff <= first_ff;
                    cmd_ff    <= mo_ff;
                    first_ff  <= 1'b0;
                end
            end
        end
    end

    a_idle_miso_low: assert property (cs_n [*6] |-> !miso)
        else $error("miso not low while deselected");
    a_miso_edge_window: assert property (!cs_n && $changed(miso) |-> since_ff <= 5'h06)
        else $error("miso moved away from a clock fall");
    a_select_miso_low: assert property ($fell(cs_n) |-> !miso)
        else $error("miso not low at frame start");
    a_write_reply_zero: assert property (done_ff && rcmd_ff[15] |-> rep_ff == 16'h0000)
        else $error("write answered with data");
    a_unmapped_zero: assert property (done_ff && (rcmd_ff[14:8] < 7'h04 ||
        rcmd_ff[14:8] > 7'h17) |-> rep_ff == 16'h0000) else $error("unmapped read not zero");
    a_first_reply_zero: assert property (done_ff && rfirst_ff |-> rep_ff == 16'h0000)
        else $error("first reply after reset not zero");
    a_rate_high_range: assert property (done_ff && !rfirst_ff && !rcmd_ff[15] &&
        rcmd_ff[14:9] inside {6'h03, 6'h05, 6'h07} |-> $signed(rep_ff) <= $signed(16'h4E20)
        && $signed(rep_ff) >= $signed(16'hB1E0)) else $error("rate high word out of range");
    a_accel_high_range: assert property (done_ff && !rfirst_ff && !rcmd_ff[15] &&
        rcmd_ff[14:9] inside {6'h09, 6'h0B} |-> $signed(rep_ff) <= $signed(16'h7D00)
        && $signed(rep_ff) >= $signed(16'h8300)) else $error("accel high word out of range");

    c_accel_read: cover property (done_ff && !rcmd_ff[15] && rcmd_ff[14:8] == 7'h12);
    c_write: cover property (done_ff && rcmd_ff[15]);
    c_saturate: cover property (sample_valid && sample.accel_x > `ACCEL_MAX);
endmodule : inertial_output_registers_checker

bind inertial_output_registers
    inertial_output_registers_checker u_inertial_output_registers_checker (
    .core_clk(core_clk), .arst_n(arst_n), .sample_valid(sample_valid), .sample(sample),
    .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso));

// ==== sim/tb_top.sv ====
/*
 * Self-checking bench for the inertial output register bank: loads samples, reads words.
 * Assumes the host model and the bound checker are compiled before it.
 */
`timescale 1ns/1ps

module tb_top
    import imu_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        sample_valid = 1'b0;
    sample_t     sample = '0;
    logic        cs_n, sclk, mosi, miso;
    int          mismatches = 0;
    int          n_checks = 0;
    logic [15:0] rx;
    logic [31:0] w;
    sample_t     s1 = {32'h1234_5678, 32'hFFFF_FFFE, 32'h0000_0001, 32'h8300_0000, 32'h7D00_0000};
    sample_t     s2 = {32'h6000_0000, 32'hA000_0000, 32'h0000_0000, 32'h7FFF_FFFF, 32'h8000_0000};

    always #5 core_clk = ~core_clk;

    inertial_output_registers u_inertial_output_registers (.core_clk(core_clk), .arst_n(arst_n),
        .sample_valid(sample_valid), .sample(sample), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
        .miso(miso));
    spi_host_model u_spi_host_model (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk),
        .mosi(mosi), .miso(miso));

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic load(input sample_t s);
        @(posedge core_clk);
        sample       <= s;
        sample_valid <= 1'b1;
        @(posedge core_clk);
        sample_valid <= 1'b0;
    endtask : load

    task automatic xfer(input spi_cmd_t c);
        u_spi_host_model.xfer(c, rx);
    endtask : xfer

    // The answer to a command comes back in the following frame
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        xfer('{1'b0, a, 8'h00});
        xfer('0);
        check(rx, exp);
    endtask : rd

    task automatic do_reset();
        @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
    endtask : do_reset

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (40000) @(posedge core_clk);
        mismatches++;
        print_verdict();
    end

    initial begin
        do_reset();
        xfer('{1'b0, 7'h06, 8'h00});
        check(rx, 16'h0000);
        load(s1);
        for (int i = 0; i < 10; i++) begin
            w = 32'(s1 >> (32 * (4 - i / 2)));
            rd(7'(4 + 2 * i), i[0] ? w[31:16] : w[15:0]);
        end
        rd(7'h07, 16'h1234);
        rd(7'h17, 16'h7D00);
        load(s2);
        rd(7'h04, 16'h0000);
        rd(7'h06, 16'h4E20);
        rd(7'h0A, 16'hB1E0);
        rd(7'h0E, 16'h0000);
        rd(7'h12, 16'h7D00);
        rd(7'h16, 16'h8300);
        rd(7'h14, 16'h0000);
        load(s1);
        rd(7'h10, 16'h0000);
        load(s2);
        rd(7'h12, 16'h8300);
        rd(7'h12, 16'h7D00);
        xfer('{1'b1, 7'h12, 8'hAA});
        xfer('{1'b0, 7'h12, 8'h00});
        check(rx, 16'h0000);
        xfer('0);
        check(rx, 16'h7D00);
        rd(7'h00, 16'h0000);
        rd(7'h18, 16'h0000);
        do_reset();
        xfer('{1'b0, 7'h06, 8'h00});
        check(rx, 16'h0000);
        load(s1);
        rd(7'h06, 16'h1234);
        print_verdict();
    end
endmodule : tb_top
